// [rtl/fmr_monitor.sv]
/*
  Fault and operating-condition monitor: sensors, memory parity, EEPROM
  error events, stack limits, watchdog, cause registers, interrupt.
  Assumes sensor and high-voltage pins are asynchronous, all other inputs
  share CLK, RST is the system reset and POR only the power-on reset.
*/
// Summary of operation
// - Sensor alarm out of range forces reset or raises exception per sensor.
// - Inverse ECC option turns each EEPROM ECC error into an exception.
// - RAM stores byte parity and checks it on every read of a word written since reset.
// - RAM parity error from read or scan forces security reset.
// - Every security reset restores reset values and leaves a readable reset cause.
// - Each exception leaves its reason readable in a cause register.
// - Sensor enables read as on and ignore every software write.
// - Three stack pointers each have their own limit checker.
// - Active stack pointer leaving its limits raises an exception.
// - EEPROM write high voltage is checked and latched, no event raised.
// - Watchdog stays idle until software enables and configures it.
// - ROM parity error forces reset like RAM parity error.
`timescale 1ns/1ps
module fmr_monitor
  import fmr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic [REG_AW-1:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DW-1:0] RDATA,
  input wire logic [NSENS-1:0] SENS_ALARM,
  input wire logic ECC_ERR,
  input wire logic ROM_PAR_ERR,
  input wire logic EE_WR_ACTIVE,
  input wire logic HV_OK,
  input wire logic [1:0] PRIV_MODE,
  input wire logic [SP_W-1:0] SP_USR,
  input wire logic [SP_W-1:0] SP_SYS,
  input wire logic [SP_W-1:0] SP_SSM,
  input wire logic RAM_REQ,
  input wire logic RAM_WE,
  input wire logic [RAM_AW-1:0] RAM_ADDR,
  input wire logic [8*RAM_NB-1:0] RAM_WDATA,
  output logic [8*RAM_NB-1:0] RAM_RDATA,
  output logic SEC_RST,
  output logic EXC,
  output logic IRQ,
  output logic ECC_CORR_EN,
  output logic DBL_READ_EN,
  output logic [NSENS-1:0] SENS_EN
);
  logic [CTRL_W-1:0] ctrl_r;
  logic [WDG_W-1:0] wdg_load_r, wdg_cnt_r;
  logic [RC_W-1:0] rst_cause_r;
  logic [EXC_W-1:0] exc_cause_r, irq_stat_r, irq_mask_r;
  logic [SP_W-1:0] sp_lo_r [NMODE];
  logic [SP_W-1:0] sp_hi_r [NMODE];
  logic [NSENS-1:0] sens_s1_r, sens_s2_r, sens_d_r;
  logic hv_s1_r, hv_s2_r, hv_fail_r;
  fmr_hv_t hv_st_r, hv_nxt;
  logic sec_rst_r, exc_r;
  logic [DW-1:0] rdata_r;
  logic [NMODE-1:0] sp_viol;
  logic ram_par_err;

  function automatic logic [REG_AW-1:0] sp_ofs(input int m, input logic hi);
    return (hi ? OFS_SP_HI0 : OFS_SP_LO0) + REG_AW'(m) * OFS_SP_STEP;
  endfunction

  // Register write decode.
  wire wr_ctrl = WR && (ADDR == OFS_CTRL);
  wire wr_load = WR && (ADDR == OFS_WDG_LOAD);
  wire wr_kick = WR && (ADDR == OFS_WDG_KICK);
  wire wr_rc = WR && (ADDR == OFS_RST_CAUSE);
  wire wr_stat = WR && (ADDR == OFS_IRQ_STAT);
  wire wr_mask = WR && (ADDR == OFS_IRQ_MASK);

  // Sensor enables are hard wired; a write to their offset changes nothing.
  assign SENS_EN = SENS_EN_ALL;
  assign ECC_CORR_EN = !ctrl_r[CTRL_INV_ECC];
  assign DBL_READ_EN = ctrl_r[CTRL_DBL_RD];

  // Two-flop synchronisers for the asynchronous sensor and voltage pins.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sens_s1_r <= '0;
      sens_s2_r <= '0;
      sens_d_r <= '0;
      hv_s1_r <= 1'b0;
      hv_s2_r <= 1'b0;
    end else begin
      sens_s1_r <= SENS_ALARM;
      sens_s2_r <= sens_s1_r;
      sens_d_r <= sens_s2_r;
      hv_s1_r <= HV_OK;
      hv_s2_r <= hv_s1_r;
    end
  end

  // A held alarm reports once, on its rising edge, so a slow sensor
  // cannot flood the core with exceptions.
  wire [NSENS-1:0] sens_ev = sens_s2_r & ~sens_d_r;
  wire [NSENS-1:0] sens_rst = sens_ev & SENS_RST_SEL;
  wire [NSENS-1:0] sens_exc = sens_ev & ~SENS_RST_SEL;

  // One checker per privilege level; only the level in use can fire.
  wire [SP_W-1:0] sp_in [NMODE];
  assign sp_in[0] = SP_USR;
  assign sp_in[1] = SP_SYS;
  assign sp_in[2] = SP_SSM;
  generate
    for (genvar m = 0; m < NMODE; m++) begin : g_sp
      fmr_stack_lim u_lim (
        .clk(CLK),
        .rst(RST),
        .active(PRIV_MODE == 2'(m)),
        .sp(sp_in[m]),
        .lo(sp_lo_r[m]),
        .hi(sp_hi_r[m]),
        .viol(sp_viol[m])
      );
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          sp_lo_r[m] <= SP_LO_RST;
          sp_hi_r[m] <= SP_HI_RST;
        end else begin
          if (WR && ADDR == sp_ofs(m, 1'b0)) begin
            sp_lo_r[m] <= WDATA[SP_W-1:0];
          end
          if (WR && ADDR == sp_ofs(m, 1'b1)) begin
            sp_hi_r[m] <= WDATA[SP_W-1:0];
          end
        end
      end
    end
  endgenerate

  // Parity-protected RAM with its background scanner.
  fmr_ram_par u_ram (
    .clk(CLK),
    .rst(RST),
    .cpu_req(RAM_REQ),
    .cpu_we(RAM_WE),
    .cpu_addr(RAM_ADDR),
    .cpu_wdata(RAM_WDATA),
    .cpu_rdata(RAM_RDATA),
    .par_err(ram_par_err)
  );

  // Watchdog counts down from the load value only while enabled.
  wire wdg_on = ctrl_r[CTRL_WDG_EN];
  wire wdg_exp = wdg_on && !wr_kick && (wdg_cnt_r == '0);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wdg_cnt_r <= WDG_LOAD_RST;
    end else if (!wdg_on || wr_kick || wdg_exp) begin
      wdg_cnt_r <= wdg_load_r;
    end else begin
      wdg_cnt_r <= wdg_cnt_r - 1'b1;
    end
  end

  // Gathered events: the exception class and the reset class.
  logic [EXC_W-1:0] exc_ev;
  logic [RC_W-1:0] rst_ev;
  always_comb begin
    exc_ev = '0;
    exc_ev[NSENS-1:0] = sens_exc;
    exc_ev[EXC_ECC] = ECC_ERR && ctrl_r[CTRL_INV_ECC];
    exc_ev[EXC_STACK] = |sp_viol;
    exc_ev[EXC_WDG] = wdg_exp && ctrl_r[CTRL_WDG_EXC];
    rst_ev = '0;
    rst_ev[NSENS-1:0] = sens_rst;
    rst_ev[RC_RAM] = ram_par_err;
    rst_ev[RC_ROM] = ROM_PAR_ERR;
    rst_ev[RC_WDG] = wdg_exp && !ctrl_r[CTRL_WDG_EXC];
  end

  // Control, mask and watchdog load; system reset restores all of them.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= CTRL_RST;
      wdg_load_r <= WDG_LOAD_RST;
      irq_mask_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= WDATA[CTRL_W-1:0];
      end
      if (wr_load) begin
        wdg_load_r <= WDATA[WDG_W-1:0];
      end
      if (wr_mask) begin
        irq_mask_r <= WDATA[EXC_W-1:0];
      end
    end
  end

  // Exception pulse, cause of the last exception and sticky status.
  // A new event in the clearing cycle stays set.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      exc_r <= 1'b0;
      exc_cause_r <= '0;
      irq_stat_r <= '0;
    end else begin
      exc_r <= |exc_ev;
      if (|exc_ev) begin
        exc_cause_r <= exc_ev;
      end
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? WDATA[EXC_W-1:0] : '0)) | exc_ev;
    end
  end
  assign EXC = exc_r;
  assign IRQ = |(irq_stat_r & irq_mask_r);

  // The cause survives the security reset it triggers; only power-on or a software write clears it.
  always_ff @(posedge CLK or posedge POR) begin
    if (POR) begin
      rst_cause_r <= '0;
    end else begin
      rst_cause_r <= (rst_cause_r & ~(wr_rc ? WDATA[RC_W-1:0] : '0)) | rst_ev;
    end
  end

  // Reset request is a registered one-cycle pulse to the reset generator.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sec_rst_r <= 1'b0;
    end else begin
      sec_rst_r <= |rst_ev;
    end
  end
  assign SEC_RST = sec_rst_r;

  // Voltage check follows each EEPROM write; the result is only stored.
  always_comb begin
    hv_nxt = hv_st_r;
    unique case (hv_st_r)
      FMR_HV_IDLE, FMR_HV_DONE: begin
        if (EE_WR_ACTIVE) begin
          hv_nxt = FMR_HV_RUN;
        end
      end
      FMR_HV_RUN: begin
        if (!EE_WR_ACTIVE) begin
          hv_nxt = FMR_HV_DONE;
        end
      end
      default: hv_nxt = FMR_HV_IDLE;
    endcase
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hv_st_r <= FMR_HV_IDLE;
      hv_fail_r <= 1'b0;
    end else begin
      hv_st_r <= hv_nxt;
      if (hv_st_r != FMR_HV_RUN && EE_WR_ACTIVE) begin
        hv_fail_r <= !hv_s2_r;
      end else if (hv_st_r == FMR_HV_RUN && !hv_s2_r) begin
        hv_fail_r <= 1'b1;
      end
    end
  end

  // Read mux; unmapped offsets read zero.
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (ADDR)
      OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
      OFS_WDG_LOAD: rd_mux[WDG_W-1:0] = wdg_load_r;
      OFS_WDG_KICK: rd_mux[WDG_W-1:0] = wdg_cnt_r;
      OFS_RST_CAUSE: rd_mux[RC_W-1:0] = rst_cause_r;
      OFS_EXC_CAUSE: rd_mux[EXC_W-1:0] = exc_cause_r;
      OFS_IRQ_STAT: rd_mux[EXC_W-1:0] = irq_stat_r;
      OFS_IRQ_MASK: rd_mux[EXC_W-1:0] = irq_mask_r;
      OFS_HV_STAT: begin
        rd_mux[HV_DONE_BIT] = (hv_st_r == FMR_HV_DONE);
        rd_mux[HV_FAIL_BIT] = hv_fail_r;
      end
      OFS_SENS_EN: rd_mux[NSENS-1:0] = SENS_EN;
      default: begin
        for (int m = 0; m < NMODE; m++) begin
          if (ADDR == sp_ofs(m, 1'b0)) rd_mux[SP_W-1:0] = sp_lo_r[m];
          if (ADDR == sp_ofs(m, 1'b1)) rd_mux[SP_W-1:0] = sp_hi_r[m];
        end
      end
    endcase
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= RD ? rd_mux : '0;
    end
  end
  assign RDATA = rdata_r;

  // Checks kept beside the logic.
  a_sens_exc_pulse: assert property (@(posedge CLK) disable iff (RST)
    |sens_exc |=> EXC && exc_cause_r[NSENS-1:0] == $past(sens_exc))
    else $error("sensor exception not reported");
  a_ecc_inverse: assert property (@(posedge CLK) disable iff (RST)
    ECC_ERR && ctrl_r[CTRL_INV_ECC] |=> EXC && exc_cause_r[EXC_ECC])
    else $error("ecc error did not raise exception");
  a_ecc_quiet: assert property (@(posedge CLK) disable iff (RST)
    ECC_ERR && !ctrl_r[CTRL_INV_ECC] |=> !irq_stat_r[EXC_ECC] || $past(irq_stat_r[EXC_ECC]))
    else $error("ecc error flagged with option off");
  a_ram_par_rst: assert property (@(posedge CLK) disable iff (RST || POR)
    ram_par_err |=> SEC_RST && rst_cause_r[RC_RAM])
    else $error("ram parity error did not reset");
  a_rom_par_rst: assert property (@(posedge CLK) disable iff (RST || POR)
    ROM_PAR_ERR |=> SEC_RST && rst_cause_r[RC_ROM])
    else $error("rom parity error did not reset");
  a_sens_always_on: assert property (@(posedge CLK) disable iff (RST)
    WR && ADDR == OFS_SENS_EN |=> SENS_EN == SENS_EN_ALL && $stable(ctrl_r))
    else $error("sensor enable changed by software");
  a_stack_exc: assert property (@(posedge CLK) disable iff (RST)
    |sp_viol |=> EXC && exc_cause_r[EXC_STACK] && irq_stat_r[EXC_STACK])
    else $error("stack violation not reported");
  a_hv_no_event: assert property (@(posedge CLK) disable iff (RST)
    $rose(hv_fail_r) && !(|exc_ev) && !(|rst_ev) |=> !EXC ##0 !SEC_RST)
    else $error("voltage check raised an event");
  a_wdg_idle: assert property (@(posedge CLK) disable iff (RST)
    !wdg_on [*2] |-> wdg_cnt_r == $past(wdg_load_r) && !wdg_exp)
    else $error("watchdog counting while disabled");
  a_cause_sticky: assert property (@(posedge CLK) disable iff (POR)
    !wr_rc |=> (rst_cause_r & $past(rst_cause_r)) == $past(rst_cause_r))
    else $error("reset cause lost");
endmodule // fmr_monitor

// [rtl/fmr_pkg.sv]
/*
  Constants shared by the fault monitor: register offsets, field
  positions, reset values and state codes.
  Assumes a 32-bit register port with byte offsets on 8 address bits.
*/
package fmr_pkg;
  localparam int REG_AW = 8;
  localparam int DW = 32;
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFS_WDG_LOAD = 8'h04;
  localparam logic [REG_AW-1:0] OFS_WDG_KICK = 8'h08;
  localparam logic [REG_AW-1:0] OFS_RST_CAUSE = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_EXC_CAUSE = 8'h10;
  localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [REG_AW-1:0] OFS_HV_STAT = 8'h1c;
  localparam logic [REG_AW-1:0] OFS_SENS_EN = 8'h20;
  localparam logic [REG_AW-1:0] OFS_SP_LO0 = 8'h30;
  localparam logic [REG_AW-1:0] OFS_SP_HI0 = 8'h34;
  localparam logic [REG_AW-1:0] OFS_SP_STEP = 8'h08;
  // Control bits.
  localparam int CTRL_W = 4;
  localparam int CTRL_INV_ECC = 0;
  localparam int CTRL_DBL_RD = 1;
  localparam int CTRL_WDG_EN = 2;
  localparam int CTRL_WDG_EXC = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  // Exception cause bits, also the interrupt status layout.
  localparam int NSENS = 4;
  localparam int EXC_W = 7;
  localparam int EXC_ECC = 4;
  localparam int EXC_STACK = 5;
  localparam int EXC_WDG = 6;
  // Reset cause bits; the low ones are the sensors.
  localparam int RC_W = 7;
  localparam int RC_RAM = 4;
  localparam int RC_ROM = 5;
  localparam int RC_WDG = 6;
  localparam logic [NSENS-1:0] SENS_EN_ALL = 4'hf;
  localparam logic [NSENS-1:0] SENS_RST_SEL = 4'h3;
  // Stack limits, three privilege levels.
  localparam int NMODE = 3;
  localparam int SP_W = 16;
  localparam logic [SP_W-1:0] SP_LO_RST = 16'h0000;
  localparam logic [SP_W-1:0] SP_HI_RST = 16'hffff;
  // Watchdog.
  localparam int WDG_W = 16;
  localparam logic [WDG_W-1:0] WDG_LOAD_RST = 16'hffff;
  // High-voltage check status bits.
  localparam int HV_DONE_BIT = 0;
  localparam int HV_FAIL_BIT = 1;
  // RAM and its scanner.
  localparam int RAM_AW = 6;
  localparam int RAM_NB = 4;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  typedef enum logic [2:0] {
    FMR_HV_IDLE = 3'b001,
    FMR_HV_RUN = 3'b010,
    FMR_HV_DONE = 3'b100
  } fmr_hv_t;
endpackage

// [rtl/fmr_stack_lim.sv]
/*
  Limit checker for one stack pointer.
  Assumes pointer and limits come from logic on the same clock.
*/
`timescale 1ns/1ps
module fmr_stack_lim
  import fmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic active,
  input wire logic [SP_W-1:0] sp,
  input wire logic [SP_W-1:0] lo,
  input wire logic [SP_W-1:0] hi,
  output logic viol
);
  logic out_r;
  wire out_now = active && ((sp < lo) || (sp > hi));

  // Only the entry into the bad range is reported, so one excursion is one exception.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_now;
    end
  end
  assign viol = out_now && !out_r;
endmodule // fmr_stack_lim

// [rtl/fmr_ram_par.sv]
/*
  Byte-parity RAM with a background scanner.
  Assumes the core drives its request on the same clock; read data
  follow one cycle after a read and are valid only then.
*/
`timescale 1ns/1ps
module fmr_ram_par
  import fmr_pkg::*;
#(
  parameter int AW = RAM_AW,
  parameter int NB = RAM_NB
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [AW-1:0] cpu_addr,
  input wire logic [8*NB-1:0] cpu_wdata,
  output logic [8*NB-1:0] cpu_rdata,
  output logic par_err
);
  logic [8*NB-1:0] mem [2**AW];
  logic [NB-1:0] par [2**AW];
  logic [2**AW-1:0] seen_r;
  logic [AW-1:0] cnt_r;
  logic [AW-1:0] key_r;
  logic [15:0] lfsr_r;
  logic [NB-1:0] rd_par_r;
  logic chk_r;

  function automatic logic [NB-1:0] byte_par(input logic [8*NB-1:0] d);
    logic [NB-1:0] p;
    p = '0;
    for (int i = 0; i < NB; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

  // The core always wins the port, so it never waits for the scanner.
  wire [AW-1:0] addr = cpu_req ? cpu_addr : (cnt_r ^ key_r);
  wire wr = cpu_req && cpu_we;

  // Array has no reset; words never written are not checked.
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[addr] <= cpu_wdata;
      par[addr] <= byte_par(cpu_wdata);
    end
    cpu_rdata <= mem[addr];
    rd_par_r <= par[addr];
  end

  // Scan pass covers every address; the key changes order between passes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_r <= '0;
      cnt_r <= '0;
      key_r <= '0;
      lfsr_r <= LFSR_SEED;
      chk_r <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[14:0], ^(lfsr_r & LFSR_TAPS)};
      if (wr) begin
        seen_r[addr] <= 1'b1;
      end
      if (!cpu_req) begin
        cnt_r <= cnt_r + 1'b1;
        if (&cnt_r) begin
          key_r <= lfsr_r[AW-1:0];
        end
      end
      chk_r <= !wr && seen_r[addr];
    end
  end
  assign par_err = chk_r && (rd_par_r != byte_par(cpu_rdata));
endmodule // fmr_ram_par

// [test/fmr_core_model.sv]
/*
  Core-side model: drives the register port and the RAM port of the monitor.
  Assumes the monitor samples both ports on the rising edge of clk and never stalls.
*/
`timescale 1ns/1ps
module fmr_core_model
  import fmr_pkg::*;
(
  input wire logic clk,
  output logic [REG_AW-1:0] addr,
  output logic [DW-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [DW-1:0] rdata,
  output logic ram_req,
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [8*RAM_NB-1:0] ram_wdata,
  input wire logic [8*RAM_NB-1:0] ram_rdata
);
  // Idle at time zero; strobes low so nothing is taken before reset ends.
  initial begin
    {addr, wdata, wr, rd} = '0;
    {ram_req, ram_we, ram_addr, ram_wdata} = '0;
  end

  // One-cycle write; released data are inverted so a stale word never looks valid.
  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // Read data are taken in the cycle after the strobe and only there.
  task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Single RAM write request.
  task automatic ram_wr(input logic [RAM_AW-1:0] a, input logic [8*RAM_NB-1:0] d);
    @(posedge clk);
    {ram_req, ram_we, ram_addr, ram_wdata} <= {2'b11, a, d};
    @(posedge clk);
    {ram_req, ram_we, ram_wdata} <= {2'b00, ~d};
  endtask

  // Two reads on back-to-back cycles; the scanner must never delay the second.
  task automatic ram_rd2(input logic [RAM_AW-1:0] a, output logic [8*RAM_NB-1:0] d0,
                         output logic [8*RAM_NB-1:0] d1);
    @(posedge clk);
    {ram_req, ram_we, ram_addr} <= {2'b10, a};
    @(posedge clk);
    ram_addr <= a + 6'h01;
    #1;
    d0 = ram_rdata;
    @(posedge clk);
    ram_req <= 1'b0;
    #1;
    d1 = ram_rdata;
  endtask
endmodule // fmr_core_model

// [test/fmr_monitor_tb.sv]
/*
  Self-checking bench for the fault monitor: one task per scenario.
  Assumes the core model in fmr_core_model.sv and the package fmr_pkg.
*/
`timescale 1ns/1ps
module fmr_monitor_tb;
  import fmr_pkg::*;
  logic CLK, RST, POR, WR, RD, ECC_ERR, ROM_PAR_ERR, EE_WR_ACTIVE, HV_OK, RAM_REQ, RAM_WE;
  logic SEC_RST, EXC, IRQ, ECC_CORR_EN, DBL_READ_EN;
  logic [REG_AW-1:0] ADDR;
  logic [DW-1:0] WDATA, RDATA, d, d1;
  logic [NSENS-1:0] SENS_ALARM, SENS_EN;
  logic [1:0] PRIV_MODE;
  logic [SP_W-1:0] SP_USR, SP_SYS, SP_SSM;
  logic [RAM_AW-1:0] RAM_ADDR;
  logic [8*RAM_NB-1:0] RAM_WDATA, RAM_RDATA;
  int err_total = 0, compares = 0, exc_n = 0, sec_n = 0, e0, s0;

  fmr_monitor uut (.CLK(CLK), .RST(RST), .POR(POR), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SENS_ALARM(SENS_ALARM), .ECC_ERR(ECC_ERR),
    .ROM_PAR_ERR(ROM_PAR_ERR), .EE_WR_ACTIVE(EE_WR_ACTIVE), .HV_OK(HV_OK),
    .PRIV_MODE(PRIV_MODE), .SP_USR(SP_USR), .SP_SYS(SP_SYS), .SP_SSM(SP_SSM),
    .RAM_REQ(RAM_REQ), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
    .RAM_RDATA(RAM_RDATA), .SEC_RST(SEC_RST), .EXC(EXC), .IRQ(IRQ),
    .ECC_CORR_EN(ECC_CORR_EN), .DBL_READ_EN(DBL_READ_EN), .SENS_EN(SENS_EN));

  fmr_core_model u_core (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD),
    .rdata(RDATA), .ram_req(RAM_REQ), .ram_we(RAM_WE), .ram_addr(RAM_ADDR),
    .ram_wdata(RAM_WDATA), .ram_rdata(RAM_RDATA));

  // Free-running 125 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // Count one-cycle event pulses so no pulse is missed between checks.
  always @(posedge CLK) begin
    if (EXC === 1'b1) exc_n++;
    if (SEC_RST === 1'b1) sec_n++;
  end

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [REG_AW-1:0] a, input logic [DW-1:0] exp, input string n);
    u_core.reg_rd(a, d);
    chk(n, exp, d);
  endtask

  task automatic final_report();
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset();
    rchk(OFS_CTRL, 32'h0, "ctrl");
    rchk(OFS_WDG_LOAD, 32'h0000ffff, "wdg_load");
    rchk(OFS_SP_HI0 + OFS_SP_STEP, 32'h0000ffff, "sp_hi_sys");
    rchk(8'hfc, 32'h0, "unmapped");
    chk("corr_en", 32'h1, {31'h0, ECC_CORR_EN});
  endtask

  task automatic t_ctrl();
    u_core.reg_wr(OFS_SENS_EN, 32'h0);
    rchk(OFS_SENS_EN, 32'hf, "sens_en_reg");
    chk("sens_en", 32'hf, {28'h0, SENS_EN});
    u_core.reg_wr(OFS_CTRL, 32'h2);
    rchk(OFS_CTRL, 32'h2, "ctrl_dbl");
    chk("dbl_on", 32'h1, {31'h0, DBL_READ_EN});
    u_core.reg_wr(OFS_CTRL, 32'h0);
    rchk(OFS_CTRL, 32'h0, "ctrl_off");
    chk("dbl_off", 32'h0, {31'h0, DBL_READ_EN});
  endtask

  // One-cycle pulse on a same-clock event input, then time for the answer.
  task automatic pulse(input bit rom);
    @(posedge CLK);
    if (rom) ROM_PAR_ERR <= 1'b1;
    else ECC_ERR <= 1'b1;
    @(posedge CLK);
    {ROM_PAR_ERR, ECC_ERR} <= 2'b00;
    repeat (3) @(posedge CLK);
  endtask

  task automatic t_ecc();
    u_core.reg_wr(OFS_IRQ_STAT, 32'h7f);
    u_core.reg_wr(OFS_IRQ_MASK, 32'h10);
    u_core.reg_wr(OFS_CTRL, 32'h1);
    e0 = exc_n;
    pulse(1'b0);
    chk("ecc_exc", 32'h1, exc_n - e0);
    chk("corr_off", 32'h0, {31'h0, ECC_CORR_EN});
    rchk(OFS_EXC_CAUSE, 32'h10, "exc_cause_ecc");
    chk("irq_on", 32'h1, {31'h0, IRQ});
    u_core.reg_wr(OFS_IRQ_STAT, 32'h10);
    rchk(OFS_IRQ_STAT, 32'h0, "irq_stat_clr");
    chk("irq_off", 32'h0, {31'h0, IRQ});
    u_core.reg_wr(OFS_CTRL, 32'h0);
    e0 = exc_n;
    pulse(1'b0);
    chk("ecc_silent", 32'h0, exc_n - e0);
  endtask

  task automatic t_sensor();
    u_core.reg_wr(OFS_RST_CAUSE, 32'h7f);
    s0 = sec_n;
    e0 = exc_n;
    SENS_ALARM <= 4'h1;
    repeat (8) @(posedge CLK);
    chk("sens_rst", 32'h1, sec_n - s0);
    SENS_ALARM <= 4'h5;
    repeat (8) @(posedge CLK);
    chk("sens_exc", 32'h1, exc_n - e0);
    chk("sens_held", 32'h1, sec_n - s0);
    rchk(OFS_EXC_CAUSE, 32'h4, "exc_cause_sens");
    SENS_ALARM <= 4'h0;
    u_core.reg_wr(OFS_CTRL, 32'h2);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rchk(OFS_RST_CAUSE, 32'h1, "rst_cause_kept");
    rchk(OFS_CTRL, 32'h0, "ctrl_after_rst");
  endtask

  task automatic t_rom();
    u_core.reg_wr(OFS_RST_CAUSE, 32'h7f);
    s0 = sec_n;
    pulse(1'b1);
    chk("rom_rst", 32'h1, sec_n - s0);
    rchk(OFS_RST_CAUSE, 32'h20, "rst_cause_rom");
  endtask

  task automatic t_stack();
    u_core.reg_wr(OFS_SP_LO0, 32'h100);
    u_core.reg_wr(OFS_SP_HI0, 32'h200);
    e0 = exc_n;
    SP_USR <= 16'h0300;
    repeat (10) @(posedge CLK);
    chk("stack_usr", 32'h1, exc_n - e0);
    rchk(OFS_EXC_CAUSE, 32'h20, "exc_cause_stack");
    u_core.reg_wr(OFS_SP_HI0 + OFS_SP_STEP, 32'h400);
    PRIV_MODE <= 2'd1;
    repeat (5) @(posedge CLK);
    chk("stack_sys_ok", 32'h1, exc_n - e0);
    SP_SYS <= 16'h0500;
    repeat (10) @(posedge CLK);
    chk("stack_sys", 32'h2, exc_n - e0);
    SP_SYS <= 16'h0150;
    u_core.reg_wr(OFS_SP_LO0 + OFS_SP_STEP + OFS_SP_STEP, 32'h200);
    PRIV_MODE <= 2'd2;
    repeat (5) @(posedge CLK);
    chk("stack_ssm", 32'h3, exc_n - e0);
    SP_USR <= 16'h0150;
    SP_SYS <= 16'h0150;
    @(posedge CLK);
    PRIV_MODE <= 2'd0;
  endtask

  task automatic t_ram();
    u_core.ram_wr(6'h05, 32'h1234abcd);
    u_core.ram_wr(6'h06, 32'h5a0f00ff);
    s0 = sec_n;
    repeat (300) @(posedge CLK);
    chk("scan_clean", 32'h0, sec_n - s0);
    u_core.ram_rd2(6'h05, d, d1);
    chk("ram_rd0", 32'h1234abcd, d);
    chk("ram_rd1", 32'h5a0f00ff, d1);
  endtask

  task automatic t_hv();
    e0 = exc_n;
    s0 = sec_n;
    {EE_WR_ACTIVE, HV_OK} <= 2'b10;
    repeat (6) @(posedge CLK);
    {EE_WR_ACTIVE, HV_OK} <= 2'b01;
    repeat (6) @(posedge CLK);
    rchk(OFS_HV_STAT, 32'h3, "hv_fail");
    EE_WR_ACTIVE <= 1'b1;
    repeat (6) @(posedge CLK);
    EE_WR_ACTIVE <= 1'b0;
    repeat (6) @(posedge CLK);
    rchk(OFS_HV_STAT, 32'h1, "hv_good");
    chk("hv_no_event", 32'h0, (exc_n - e0) + (sec_n - s0));
  endtask

  task automatic t_wdg();
    e0 = exc_n;
    u_core.reg_wr(OFS_WDG_LOAD, 32'h10);
    u_core.reg_wr(OFS_WDG_KICK, 32'h0);
    repeat (40) @(posedge CLK);
    chk("wdg_idle", 32'h0, exc_n - e0);
    rchk(OFS_WDG_KICK, 32'h10, "wdg_cnt_idle");
    u_core.reg_wr(OFS_CTRL, 32'hc);
    u_core.reg_wr(OFS_WDG_KICK, 32'h0);
    repeat (40) @(posedge CLK);
    chk("wdg_exc", 32'h2, exc_n - e0);
    rchk(OFS_EXC_CAUSE, 32'h40, "exc_cause_wdg");
    u_core.reg_wr(OFS_RST_CAUSE, 32'h7f);
    u_core.reg_wr(OFS_CTRL, 32'h4);
    u_core.reg_wr(OFS_WDG_KICK, 32'h0);
    repeat (40) @(posedge CLK);
    u_core.reg_wr(OFS_CTRL, 32'h0);
    rchk(OFS_RST_CAUSE, 32'h40, "rst_cause_wdg");
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    final_report();
  end

  // Main sequence: reset for five cycles, then the scenarios.
  initial begin
    {RST, POR} = 2'b11;
    {SENS_ALARM, ECC_ERR, ROM_PAR_ERR, EE_WR_ACTIVE, PRIV_MODE} = '0;
    HV_OK = 1'b1;
    SP_USR = 16'h0150;
    SP_SYS = 16'h0150;
    SP_SSM = 16'h0150;
    repeat (5) @(posedge CLK);
    {RST, POR} <= 2'b00;
    t_reset();
    t_ctrl();
    t_ecc();
    t_sensor();
    t_rom();
    t_stack();
    t_ram();
    t_hv();
    t_wdg();
    final_report();
  end
endmodule // fmr_monitor_tb
